/* File: rtl/cce_pkg.sv */
// package of constants for the comparator control and event block
package cce_pkg;
  // ==========================================================
  // channel count, field widths and synchroniser length
  localparam int unsigned CCE_NUM_CHAN = 3;
  localparam int unsigned CCE_SPEED_W  = 2;
  localparam int unsigned CCE_HYST_W   = 2;
  localparam int unsigned CCE_SYNC_LEN = 3;

  // ==========================================================
  // control register bit positions
  localparam int unsigned CTL_ON_BIT   = 7;
  localparam int unsigned CTL_RES_BIT  = 6;
  localparam int unsigned CTL_RISE_BIT = 5;
  localparam int unsigned CTL_FALL_BIT = 4;
  localparam int unsigned CTL_HYP_LSB  = 2;
  localparam int unsigned CTL_HYN_LSB  = 0;

  // ==========================================================
  // mode register bit positions
  localparam int unsigned MD_RIE_BIT   = 5;
  localparam int unsigned MD_FIE_BIT   = 4;
  localparam int unsigned MD_SPEED_LSB = 0;

  // ==========================================================
  // reset values
  localparam logic [7:0] CTL_RESET_VAL   = 8'h00;
  localparam logic [7:0] MD_RESET_VAL    = 8'h02;
  localparam logic [1:0] SPEED_RESET_VAL = 2'h2;

  // ==========================================================
  // hysteresis codes, same for both directions
  localparam logic [1:0] HYST_OFF   = 2'h0;
  localparam logic [1:0] HYST_5MV   = 2'h1;
  localparam logic [1:0] HYST_10MV  = 2'h2;
  localparam logic [1:0] HYST_20MV  = 2'h3;

  // ==========================================================
  // response speed modes
  localparam logic [1:0] SPEED_FASTEST  = 2'h0;
  localparam logic [1:0] SPEED_LOWPOWER = 2'h3;

  // ==========================================================
  // power-up wait that software must respect, in ns and in cycles
  localparam int unsigned CLK_PERIOD_NS    = 50;
  localparam int unsigned POWERUP_NS       = 10000;
  localparam int unsigned POWERUP_CYCLES   = POWERUP_NS / CLK_PERIOD_NS;
endpackage

/* File: rtl/cce_channel.sv */
// one comparator channel: input synchroniser, edge detect and sticky flags
`timescale 1ns/100ps
module cce_channel
  import cce_pkg::*;
(
  // clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // analog side
  input  wire logic raw_result,
  // control
  input  wire logic channel_on_bit,
  input  wire logic rise_clear,
  input  wire logic fall_clear,
  // status
  output logic      compare_result_bit,
  output logic      rise_seen_flag,
  output logic      fall_seen_flag
);
  // ==========================================================
  // synchroniser and flags
  logic [CCE_SYNC_LEN-1:0] sync_q;
  logic [CCE_SYNC_LEN-1:0] sync_d;
  logic                    stable_q;
  logic                    stable_d;
  logic                    rise_q;
  logic                    rise_d;
  logic                    fall_q;
  logic                    fall_d;
  logic                    rise_ev;
  logic                    fall_ev;

  always_comb begin
    sync_d   = {sync_q[CCE_SYNC_LEN-2:0], raw_result};
    stable_d = stable_q;
    // a level only counts once the second and third stages agree
    if (sync_q[1] == sync_q[2]) begin
      stable_d = sync_q[2];
    end
    // disabled channel is held low so no edges arise from the off core
    if (!channel_on_bit) begin
      stable_d = 1'b0;
    end
    rise_ev = stable_d & ~stable_q;
    fall_ev = ~stable_d & stable_q;
    // set wins over clear in the same cycle
    rise_d = rise_ev | (rise_q & ~rise_clear);
    fall_d = fall_ev | (fall_q & ~fall_clear);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      sync_q   <= '0;
      stable_q <= 1'b0;
      rise_q   <= 1'b0;
      fall_q   <= 1'b0;
    end else begin
      sync_q   <= sync_d;
      stable_q <= stable_d;
      rise_q   <= rise_d;
      fall_q   <= fall_d;
    end
  end

  assign compare_result_bit = stable_q;
  assign rise_seen_flag     = rise_q;
  assign fall_seen_flag     = fall_q;

  // ==========================================================
  // checks
  property p_rise_set;
    @(posedge clock) disable iff (rst)
      (!stable_q && stable_d) |=> rise_q;
  endproperty
  a_rise_set: assert property (p_rise_set) else $error("rise flag not set");

  property p_fall_hold;
    @(posedge clock) disable iff (rst)
      (fall_q && !fall_clear) |=> fall_q;
  endproperty
  a_fall_hold: assert property (p_fall_hold) else $error("fall flag lost");

  // a new high level only counts once both late stages agreed on it
  property p_rose_sync;
    @(posedge clock) disable iff (rst)
      $rose(stable_q) |-> ($past(sync_q[1]) && $past(sync_q[2]) && $past(channel_on_bit));
  endproperty
  a_rose_sync: assert property (p_rose_sync) else $error("result rose unsynchronised");
endmodule

/* File: rtl/cce_top.sv */
// comparator control and event logic for three channels
// Summary of operation
// - writing the on bit one powers a comparator, zero shuts it down
// - three channels, each with independent enable control
// - a disabled comparator drives logic low toward its port pin
// - result readable, interrupt source, reset source and pin output
// - result bit readable anytime without side effects
// - two-bit response speed per channel goes to the analog core
// - low four control bits hold hysteresis and drive the core
// - negative hysteresis: off, 5, 10 or 20 mV
// - positive hysteresis field is separate and independent
// - rise and fall interrupt allows select which edges interrupt
// - falling output sets fall flag, rising output sets rise flag
// - edge flags stay set until software clears them
// - hysteresis codes 00 off, 01 5mV, 10 10mV, 11 20mV
// - speed mode 0 fastest to 3 lowest power, mode reset 00000010
// - control bits 7 on, 6 result, 5 rise, 4 fall; reset zero
// - result is one when positive input exceeds negative input
`timescale 1ns/100ps
module cce_top
  import cce_pkg::*;
#(
  parameter int unsigned NUM_CHAN = CCE_NUM_CHAN
)(
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  rst,
  // control register writes, one strobe per channel
  input  wire logic [NUM_CHAN-1:0]   ctl_write,
  input  wire logic [7:0]            ctl_wdata,
  // mode register writes, one strobe per channel
  input  wire logic [NUM_CHAN-1:0]   md_write,
  input  wire logic [7:0]            md_wdata,
  // register read back, flat per channel
  output logic [NUM_CHAN*8-1:0]      comparator_control_reg,
  output logic [NUM_CHAN*8-1:0]      comparator_mode_reg,
  // analog core
  input  wire logic [NUM_CHAN-1:0]   raw_result,
  output logic [NUM_CHAN-1:0]        core_power_on,
  output logic [NUM_CHAN*2-1:0]      response_speed_field,
  output logic [NUM_CHAN*2-1:0]      positive_hyst_field,
  output logic [NUM_CHAN*2-1:0]      negative_hyst_field,
  // system side uses of the result
  output logic [NUM_CHAN-1:0]        rise_irq_req,
  output logic [NUM_CHAN-1:0]        fall_irq_req,
  output logic [NUM_CHAN-1:0]        reset_source,
  output logic [NUM_CHAN-1:0]        pin_out
);
  // ==========================================================
  // per-channel control state
  logic [NUM_CHAN-1:0]   on_q;
  logic [NUM_CHAN-1:0]   on_d;
  logic [NUM_CHAN*2-1:0] hyp_q;
  logic [NUM_CHAN*2-1:0] hyp_d;
  logic [NUM_CHAN*2-1:0] hyn_q;
  logic [NUM_CHAN*2-1:0] hyn_d;
  logic [NUM_CHAN-1:0]   rie_q;
  logic [NUM_CHAN-1:0]   rie_d;
  logic [NUM_CHAN-1:0]   fie_q;
  logic [NUM_CHAN-1:0]   fie_d;
  logic [NUM_CHAN*2-1:0] spd_q;
  logic [NUM_CHAN*2-1:0] spd_d;
  logic [NUM_CHAN-1:0]   rise_clr;
  logic [NUM_CHAN-1:0]   fall_clr;
  logic [NUM_CHAN-1:0]   result;
  logic [NUM_CHAN-1:0]   rise_flag;
  logic [NUM_CHAN-1:0]   fall_flag;

  always_comb begin
    on_d     = on_q;
    hyp_d    = hyp_q;
    hyn_d    = hyn_q;
    rie_d    = rie_q;
    fie_d    = fie_q;
    spd_d    = spd_q;
    rise_clr = '0;
    fall_clr = '0;
    for (int i = 0; i < NUM_CHAN; i++) begin
      // each channel only reacts to its own strobe
      if (ctl_write[i]) begin
        on_d[i]       = ctl_wdata[CTL_ON_BIT];
        hyp_d[i*2 +: 2] = ctl_wdata[CTL_HYP_LSB +: CCE_HYST_W];
        hyn_d[i*2 +: 2] = ctl_wdata[CTL_HYN_LSB +: CCE_HYST_W];
        // flags are clear-only from software: writing one leaves them alone
        rise_clr[i]   = ~ctl_wdata[CTL_RISE_BIT];
        fall_clr[i]   = ~ctl_wdata[CTL_FALL_BIT];
      end
      if (md_write[i]) begin
        rie_d[i]        = md_wdata[MD_RIE_BIT];
        fie_d[i]        = md_wdata[MD_FIE_BIT];
        spd_d[i*2 +: 2] = md_wdata[MD_SPEED_LSB +: CCE_SPEED_W];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      on_q  <= '0;
      hyp_q <= '0;
      hyn_q <= '0;
      rie_q <= '0;
      fie_q <= '0;
      spd_q <= {NUM_CHAN{SPEED_RESET_VAL}};
    end else begin
      on_q  <= on_d;
      hyp_q <= hyp_d;
      hyn_q <= hyn_d;
      rie_q <= rie_d;
      fie_q <= fie_d;
      spd_q <= spd_d;
    end
  end

  // ==========================================================
  // channels
  for (genvar g = 0; g < NUM_CHAN; g++) begin : g_chan
    cce_channel u_chan (
      .clock              (clock),
      .rst                (rst),
      .raw_result         (raw_result[g]),
      .channel_on_bit     (on_q[g]),
      .rise_clear         (rise_clr[g]),
      .fall_clear         (fall_clr[g]),
      .compare_result_bit (result[g]),
      .rise_seen_flag     (rise_flag[g]),
      .fall_seen_flag     (fall_flag[g])
    );
  end

  // ==========================================================
  // outputs; hysteresis codes pass straight to the core, which decodes them
  always_comb begin
    for (int i = 0; i < NUM_CHAN; i++) begin
      comparator_control_reg[i*8 +: 8] = {on_q[i], result[i], rise_flag[i], fall_flag[i],
                                          hyp_q[i*2 +: 2], hyn_q[i*2 +: 2]};
      comparator_mode_reg[i*8 +: 8]    = {2'h0, rie_q[i], fie_q[i], 2'h0,
                                          spd_q[i*2 +: 2]};
    end
  end

  assign core_power_on        = on_q;
  assign response_speed_field = spd_q;
  assign positive_hyst_field  = hyp_q;
  assign negative_hyst_field  = hyn_q;
  // interrupt requests are levels; the controller applies its own enable
  assign rise_irq_req = rise_flag & rie_q;
  assign fall_irq_req = fall_flag & fie_q;
  // result is only meaningful after the power-up wait, left to software
  assign reset_source = result;
  assign pin_out      = result & on_q;

  // ==========================================================
  // checks
  property p_pin_low;
    @(posedge clock) disable iff (rst)
      (pin_out & ~on_q) == '0;
  endproperty
  a_pin_low: assert property (p_pin_low) else $error("pin driven while off");

  property p_irq_gate;
    @(posedge clock) disable iff (rst)
      rise_irq_req == (rise_flag & rie_q);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("rise irq gating");

  property p_on_write;
    @(posedge clock) disable iff (rst)
      ctl_write[0] |=> on_q[0] == $past(ctl_wdata[CTL_ON_BIT]);
  endproperty
  a_on_write: assert property (p_on_write) else $error("enable write");

  property p_speed_write;
    @(posedge clock) disable iff (rst)
      md_write[0] |=> spd_q[1:0] == $past(md_wdata[1:0]);
  endproperty
  a_speed_write: assert property (p_speed_write) else $error("speed write");

  property p_mode_reset;
    @(posedge clock)
      rst |=> comparator_mode_reg[7:0] == MD_RESET_VAL;
  endproperty
  a_mode_reset: assert property (p_mode_reset) else $error("mode reset");

  property p_ctl_reset;
    @(posedge clock)
      rst |=> comparator_control_reg[7:0] == CTL_RESET_VAL;
  endproperty
  a_ctl_reset: assert property (p_ctl_reset) else $error("ctl reset");

  property p_hyst_hold;
    @(posedge clock) disable iff (rst)
      !ctl_write[1] |=> $stable(hyn_q[3:2]);
  endproperty
  a_hyst_hold: assert property (p_hyst_hold) else $error("hyst changed");

  property p_indep;
    @(posedge clock) disable iff (rst)
      (ctl_write == NUM_CHAN'(1)) |=> $stable(on_q[2:1]);
  endproperty
  a_indep: assert property (p_indep) else $error("channel coupling");

  // ==========================================================
  // per-channel checks, every channel held to the same rules
  for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chk
    sequence s_rise_clr_wr;
      ctl_write[c] && !ctl_wdata[CTL_RISE_BIT];
    endsequence

    sequence s_fall_clr_wr;
      ctl_write[c] && !ctl_wdata[CTL_FALL_BIT];
    endsequence

    sequence s_res_rise;
      !result[c] ##1 result[c];
    endsequence

    sequence s_res_fall;
      result[c] ##1 !result[c];
    endsequence

    property p_on_each;
      @(posedge clock) disable iff (rst)
        ctl_write[c] |=> core_power_on[c] == $past(ctl_wdata[CTL_ON_BIT]);
    endproperty
    a_on_each: assert property (p_on_each) else $error("enable write lost");

    property p_off_low;
      @(posedge clock) disable iff (rst)
        !on_q[c] |=> (!result[c] && !pin_out[c]);
    endproperty
    a_off_low: assert property (p_off_low) else $error("off channel not low");

    property p_hyst_each;
      @(posedge clock) disable iff (rst)
        ctl_write[c] |=> {positive_hyst_field[c*2 +: 2], negative_hyst_field[c*2 +: 2]}
          == $past(ctl_wdata[CTL_HYN_LSB +: 2*CCE_HYST_W]);
    endproperty
    a_hyst_each: assert property (p_hyst_each) else $error("hysteresis write lost");

    property p_speed_each;
      @(posedge clock) disable iff (rst)
        md_write[c] |=> response_speed_field[c*2 +: 2] == $past(md_wdata[MD_SPEED_LSB +: 2]);
    endproperty
    a_speed_each: assert property (p_speed_each) else $error("speed write lost");

    property p_allow_each;
      @(posedge clock) disable iff (rst)
        md_write[c] |=> {rie_q[c], fie_q[c]} == $past(md_wdata[MD_RIE_BIT -: 2]);
    endproperty
    a_allow_each: assert property (p_allow_each) else $error("edge allow write lost");

    property p_mode_hold;
      @(posedge clock) disable iff (rst)
        !md_write[c] |=> $stable(comparator_mode_reg[c*8 +: 8]);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode changed unwritten");

    // a clear in the cycle of a new edge must leave the flag set
    property p_rise_clr;
      @(posedge clock) disable iff (rst)
        s_rise_clr_wr |=> rise_flag[c] == (result[c] && !$past(result[c]));
    endproperty
    a_rise_clr: assert property (p_rise_clr) else $error("rise clear wrong");

    property p_fall_clr;
      @(posedge clock) disable iff (rst)
        s_fall_clr_wr |=> fall_flag[c] == (!result[c] && $past(result[c]));
    endproperty
    a_fall_clr: assert property (p_fall_clr) else $error("fall clear wrong");

    property p_rise_keep;
      @(posedge clock) disable iff (rst)
        (rise_flag[c] && !rise_clr[c]) |=> rise_flag[c];
    endproperty
    a_rise_keep: assert property (p_rise_keep) else $error("rise flag lost");

    property p_rise_seen;
      @(posedge clock) disable iff (rst)
        s_res_rise |-> rise_flag[c];
    endproperty
    a_rise_seen: assert property (p_rise_seen) else $error("rise not flagged");

    property p_fall_seen;
      @(posedge clock) disable iff (rst)
        s_res_fall |-> fall_flag[c];
    endproperty
    a_fall_seen: assert property (p_fall_seen) else $error("fall not flagged");

    property p_res_bit;
      @(posedge clock) disable iff (rst)
        comparator_control_reg[c*8 + CTL_RES_BIT] == reset_source[c];
    endproperty
    a_res_bit: assert property (p_res_bit) else $error("result uses disagree");

    property p_mode_unused;
      @(posedge clock) disable iff (rst)
        (comparator_mode_reg[c*8 + 7 -: 2] == 2'h0) && (comparator_mode_reg[c*8 + 3 -: 2] == 2'h0);
    endproperty
    a_mode_unused: assert property (p_mode_unused) else $error("unused mode bits set");

    property p_spd_reset;
      @(posedge clock)
        rst |=> response_speed_field[c*2 +: 2] == SPEED_RESET_VAL;
    endproperty
    a_spd_reset: assert property (p_spd_reset) else $error("speed reset");
  end
endmodule

/* File: test/cce_core_model.sv */
// behavioural analog comparator core and interrupt controller
`timescale 1ns/100ps
module cce_core_model
  import cce_pkg::*;
(
  // clock
  input  wire logic       clock,
  // from the block
  input  wire logic [2:0] core_power_on,
  input  wire logic [5:0] response_speed_field,
  input  wire logic [2:0] rise_irq_req,
  input  wire logic [2:0] fall_irq_req,
  // stimulus
  input  wire logic [2:0] pos_above_neg,
  input  wire logic [2:0] extended_irq_enable_reg,
  // to the block and the processor
  output logic [2:0]      raw_result,
  output logic            cpu_irq
);
  // ==========================================================
  // core response
  logic [3:0] delay_q [3];
  logic       junk_q = 1'b0;
  // slower modes answer later, as the real core does
  always @(posedge clock) begin
    junk_q <= ~junk_q;
    for (int i = 0; i < 3; i++) begin
      delay_q[i] <= {delay_q[i][2:0], pos_above_neg[i]};
    end
  end
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      // an unpowered core gives no valid answer, so it toggles
      raw_result[i] = core_power_on[i] ? delay_q[i][response_speed_field[2*i +: 2]] : junk_q;
    end
    cpu_irq = |((rise_irq_req | fall_irq_req) & extended_irq_enable_reg);
  end
endmodule

/* File: test/tb_cce_top.sv */
// testbench for the comparator control and event block
`timescale 1ns/100ps
module tb_cce_top;
  import cce_pkg::*;
  // ==========================================================
  // signals
  logic        clock = 1'b0;
  logic        rst;
  logic [2:0]  ctl_write, md_write, raw_result, core_power_on, pos_above_neg, eie;
  logic [7:0]  ctl_wdata, md_wdata;
  logic [23:0] comparator_control_reg, comparator_mode_reg;
  logic [5:0]  response_speed_field, positive_hyst_field, negative_hyst_field;
  logic [2:0]  rise_irq_req, fall_irq_req, reset_source, pin_out;
  logic        cpu_irq;
  int          err_count = 0;
  int          compares = 0;
  always #25 clock = ~clock;
  cce_top i_cce_top (.clock(clock), .rst(rst), .ctl_write(ctl_write), .ctl_wdata(ctl_wdata),
    .md_write(md_write), .md_wdata(md_wdata), .comparator_control_reg(comparator_control_reg),
    .comparator_mode_reg(comparator_mode_reg), .raw_result(raw_result),
    .core_power_on(core_power_on), .response_speed_field(response_speed_field),
    .positive_hyst_field(positive_hyst_field), .negative_hyst_field(negative_hyst_field),
    .rise_irq_req(rise_irq_req), .fall_irq_req(fall_irq_req), .reset_source(reset_source),
    .pin_out(pin_out));
  cce_core_model i_cce_core_model (.clock(clock), .core_power_on(core_power_on),
    .response_speed_field(response_speed_field), .rise_irq_req(rise_irq_req),
    .fall_irq_req(fall_irq_req), .pos_above_neg(pos_above_neg),
    .extended_irq_enable_reg(eie), .raw_result(raw_result), .cpu_irq(cpu_irq));
  // ==========================================================
  // tasks
  task automatic close_out();
    if (err_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one strobe cycle, then one more so the read back has landed
  task automatic wr(input logic is_md, input int ch, input logic [7:0] d);
    ctl_wdata = d;
    md_wdata = d;
    if (is_md) md_write = 3'h1 << ch;
    else ctl_write = 3'h1 << ch;
    @(negedge clock);
    ctl_write = 3'h0;
    md_write = 3'h0;
    @(negedge clock);
  endtask
  task automatic wait_ctl(input int idx, input logic v);
    int n;
    for (n = 0; n < 40 && comparator_control_reg[idx] !== v; n++) @(negedge clock);
    if (n == 40) begin
      err_count++;
      close_out();
    end
  endtask
  // ==========================================================
  // scenarios
  initial begin
    {ctl_write, md_write, ctl_wdata, md_wdata, pos_above_neg, eie} = '0;
    rst = 1'b1;
    repeat (8) @(negedge clock);
    rst = 1'b0;
    @(negedge clock);
    chk(comparator_control_reg, 24'h000000);
    chk(comparator_mode_reg, 24'h020202);
    chk(24'(response_speed_field), 24'h00002A);
    for (int s = 0; s < 4; s++) begin
      wr(1'b1, 1, 8'hCC | 8'(s));
      chk(24'(comparator_mode_reg[15:8]), 24'(s));
      chk(24'(response_speed_field[3:2]), 24'(s));
    end
    // bit6 written high must not show, the channel is off
    for (int h = 0; h < 16; h++) begin
      wr(1'b0, 2, 8'h70 | 8'(h));
      chk(24'(comparator_control_reg[23:16]), 24'(h));
      chk(24'({positive_hyst_field[5:4], negative_hyst_field[5:4]}), 24'(h));
    end
    wr(1'b1, 0, 8'h33);
    wr(1'b0, 0, 8'hB0);
    chk(24'(core_power_on), 24'h1);
    repeat (POWERUP_CYCLES) @(negedge clock);
    pos_above_neg = 3'h1;
    wait_ctl(5, 1'b1);
    chk(comparator_control_reg, 24'h0F00E0);
    chk(24'({reset_source, pin_out, rise_irq_req, fall_irq_req}), 24'h248);
    chk(24'(cpu_irq), 24'h0);
    eie = 3'h1;
    @(negedge clock);
    chk(24'(cpu_irq), 24'h1);
    repeat (20) @(negedge clock);
    chk(24'(comparator_control_reg[7:0]), 24'hE0);
    wr(1'b0, 0, 8'h90);
    chk(24'(comparator_control_reg[7:0]), 24'hC0);
    pos_above_neg = 3'h0;
    wait_ctl(4, 1'b1);
    chk(24'(comparator_control_reg[7:0]), 24'h90);
    chk(24'({pin_out[0], fall_irq_req[0], rise_irq_req[0]}), 24'h2);
    wr(1'b1, 0, 8'h23);
    chk(24'({comparator_mode_reg[7:0], fall_irq_req}), 24'h118);
    wr(1'b0, 0, 8'hA0);
    pos_above_neg = 3'h1;
    wait_ctl(5, 1'b1);
    wr(1'b0, 0, 8'h30);
    chk(24'(comparator_control_reg[7:0]), 24'h30);
    chk(24'({pin_out, core_power_on}), 24'h00);
    close_out();
  end
endmodule
